// file: hdl/flash_ctl_pkg.sv
`default_nettype none
package flash_ctl_pkg;

   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] EVENT_FLAGS_ADDR = 8'h71;
   localparam logic [7:0] CONTROL_ADDR     = 8'h72;
   localparam logic [7:0] SECTOR_WE_ADDR   = 8'h73;
   localparam logic [7:0] PROGRESS_ADDR    = 8'h74;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   // Event flag register: enable above flag, four pairs
   localparam int WDONE_EN_BIT  = 7;
   localparam int WDONE_BIT     = 6;
   localparam int WFAIL_EN_BIT  = 5;
   localparam int WFAIL_BIT     = 4;
   localparam int EDONE_EN_BIT  = 3;
   localparam int EDONE_BIT     = 2;
   localparam int EFAIL_EN_BIT  = 1;
   localparam int EFAIL_BIT     = 0;
   // Operation control register
   localparam int OPDONE_BIT    = 5;
   localparam int IDLE_BIT      = 4;
   localparam int RSVD_BIT      = 3;
   localparam int OP_EN_BIT     = 2;
   localparam int GLOBAL_EN_BIT = 1;
   localparam int SWAP_BIT      = 0;
   // Progress status register
   localparam int SUSP_BIT      = 3;
   localparam int ERASING_BIT   = 2;
   localparam int WRITING_BIT   = 1;
   localparam int FAULT_BIT     = 0;
   // Sector write enable register
   localparam int SECTOR_COUNT  = 3;
   localparam int SECTOR_RSVD_LSB = 3;
   localparam int SECTOR_RSVD_W = 5;

   // Event flag indices inside the flag bank
   localparam int FLAG_COUNT = 5;
   localparam int F_WDONE    = 0;
   localparam int F_WFAIL    = 1;
   localparam int F_EDONE    = 2;
   localparam int F_EFAIL    = 3;
   localparam int F_OPDONE   = 4;

   // ----------------------------------------
   // Reset values and timing
   // ----------------------------------------
   localparam logic [7:0] REG_RESET  = 8'h00;
   localparam int IDLE_DELAY_CYCLES  = 2;

   // ----------------------------------------
   // Address map boundaries
   // ----------------------------------------
   localparam logic [15:0] LOW_FIRST_BASE  = 16'hb000;
   localparam logic [15:0] LOW_SECOND_BASE = 16'hb800;
   localparam logic [15:0] LOW_SECOND_LAST = 16'hbfff;
   localparam logic [15:0] UPPER_BASE      = 16'hc000;
   localparam logic [15:0] VECTOR_BASE     = 16'hf800;

   typedef enum logic [1:0] {
      SEC_LOW_FIRST  = 2'b00,
      SEC_LOW_SECOND = 2'b01,
      SEC_UPPER      = 2'b10,
      SEC_NONE       = 2'b11
   } sector_t;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_ARMING  = 2'b01,
      ST_RUNNING = 2'b10
   } op_state_t;

endpackage : flash_ctl_pkg
`default_nettype wire

// file: hdl/flag_if.sv
`default_nettype none
// Set and clear requests toward one sticky event flag
interface flag_if;
   logic set;
   logic sw_clr;
   logic hw_clr;
   logic value;
   modport keeper (input set, input sw_clr, input hw_clr, output value);
   modport user   (output set, output sw_clr, output hw_clr, input value);
endinterface : flag_if
`default_nettype wire

// file: hdl/event_flag.sv
`default_nettype none
// ----------------------------------------
// Sticky event flag, set wins over clear
// ----------------------------------------
module event_flag (
   input wire logic mclk,
   input wire logic rst_n,
   flag_if.keeper   f
);
   logic value;

   // A completion arriving while software clears is kept
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         value <= 1'b0;
      end else if (f.set) begin
         value <= 1'b1;
      end else if (f.sw_clr || f.hw_clr) begin
         value <= 1'b0;
      end
   end

   assign f.value = value;
endmodule : event_flag
`default_nettype wire

// file: hdl/sector_lock.sv
`default_nettype none
// ----------------------------------------
// One sector write enable with lock-out
// ----------------------------------------
module sector_lock (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic wr,
   input wire logic wbit,
   output logic     enable
);
   logic locked;

   // Once a zero is written the sector stays shut until reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         enable <= 1'b0;
         locked <= 1'b0;
      end else if (wr) begin
         enable <= wbit & ~locked;
         locked <= locked | ~wbit;
      end
   end
endmodule : sector_lock
`default_nettype wire

// file: hdl/flash_operation_control.sv
// Decided for this implementation: the plain strobed port.
`default_nettype none
// How it works
// - Write done sets bit6; irq with bit7
// - Write fail sets bit4; irq with bit5
// - Erase done sets bit2; irq with bit3
// - Erase fail sets bit0; irq with bit1
// - Write 0 clears flags; RMW reads 1
// - Block repeat ops on stale flags
// - Failure clears matching done flag
// - Any end sets bit5; irq with bit2
// - Refuse ops while busy; read/reset passes
// - Idle falls two cycles after issue
// - Control bits 7,6 read zero
// - Global enable gates internal strobes
// - Global enable and sector enable both required
// - Swap exchanges B800 and F800 areas
// - Zero locks sector until reset
// - Progress status bits 3..0, rest zero
module flash_operation_control #(
   parameter int IDLE_DELAY = flash_ctl_pkg::IDLE_DELAY_CYCLES
) (
   input wire logic                 mclk,
   input wire logic                 rst_n,
   // Register port
   input wire logic [7:0]           bus_addr,
   input wire logic [7:0]           bus_wdata,
   input wire logic                 bus_wr,
   input wire logic                 bus_rd,
   input wire logic                 bus_rmw,
   output logic     [7:0]           bus_rdata,
   // Commands from the command decoder
   input wire logic                 cmd_write,
   input wire logic                 cmd_erase,
   input wire logic                 cmd_read_reset,
   input wire logic [15:0]          cmd_addr,
   // Reports from the automatic algorithm
   input wire logic                 alg_write_done,
   input wire logic                 alg_write_fail,
   input wire logic                 alg_erase_done,
   input wire logic                 alg_erase_fail,
   input wire logic                 command_fault,
   input wire logic                 write_in_progress,
   input wire logic                 erase_in_progress,
   input wire logic                 erase_suspended,
   // Address mapping request
   input wire logic [15:0]          map_addr,
   // Toward the array
   output logic                     flash_write_go,
   output logic                     flash_erase_go,
   output logic                     flash_read_reset_go,
   output flash_ctl_pkg::sector_t   map_sector,
   output logic                     swap_active,
   output logic                     idle_status,
   output logic                     irq
);
   import flash_ctl_pkg::*;

   localparam int CNT_W = $clog2(IDLE_DELAY + 1);
   localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(IDLE_DELAY);

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   logic                     write_done_irq_enable;
   logic                     write_fail_irq_enable;
   logic                     erase_done_irq_enable;
   logic                     erase_fail_irq_enable;
   logic                     operation_irq_enable;
   logic                     global_program_erase_enable;
   logic                     sector_swap_enable;
   logic                     control_reserved;
   logic [SECTOR_RSVD_W-1:0] sector_reserved;
   logic [SECTOR_COUNT-1:0]  sector_write_enable;

   // ----------------------------------------
   // Operation state
   // ----------------------------------------
   op_state_t                state;
   op_state_t                next_state;
   logic [CNT_W-1:0]         arm_cnt;
   logic                     write_seen;
   logic                     erase_seen;
   logic                     op_seen;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   wire sel_events   = (bus_addr == EVENT_FLAGS_ADDR);
   wire sel_control  = (bus_addr == CONTROL_ADDR);
   wire sel_sector   = (bus_addr == SECTOR_WE_ADDR);
   wire sel_progress = (bus_addr == PROGRESS_ADDR);
   wire wr_events    = bus_wr & sel_events;
   wire wr_control   = bus_wr & sel_control;
   wire wr_sector    = bus_wr & sel_sector;

   // ----------------------------------------
   // Event flag bank
   // ----------------------------------------
   flag_if flags [FLAG_COUNT] ();

   logic [FLAG_COUNT-1:0] flag_set;
   logic [FLAG_COUNT-1:0] flag_sw_clr;
   logic [FLAG_COUNT-1:0] flag_hw_clr;
   logic [FLAG_COUNT-1:0] flag_value;

   wire alg_end = alg_write_done | alg_write_fail | alg_erase_done | alg_erase_fail;

   // Hardware set sources
   assign flag_set[F_WDONE]  = alg_write_done;
   assign flag_set[F_WFAIL]  = alg_write_fail;
   assign flag_set[F_EDONE]  = alg_erase_done;
   assign flag_set[F_EFAIL]  = alg_erase_fail;
   assign flag_set[F_OPDONE] = alg_end;

   // A written zero clears, a written one is ignored
   assign flag_sw_clr[F_WDONE]  = wr_events & ~bus_wdata[WDONE_BIT];
   assign flag_sw_clr[F_WFAIL]  = wr_events & ~bus_wdata[WFAIL_BIT];
   assign flag_sw_clr[F_EDONE]  = wr_events & ~bus_wdata[EDONE_BIT];
   assign flag_sw_clr[F_EFAIL]  = wr_events & ~bus_wdata[EFAIL_BIT];
   assign flag_sw_clr[F_OPDONE] = wr_control & ~bus_wdata[OPDONE_BIT];

   // A fault while an operation failed withdraws the done flag
   wire write_fault = command_fault & (alg_write_fail | flag_value[F_WFAIL]);
   wire erase_fault = command_fault & (alg_erase_fail | flag_value[F_EFAIL]);
   assign flag_hw_clr[F_WDONE]  = write_fault;
   assign flag_hw_clr[F_WFAIL]  = 1'b0;
   assign flag_hw_clr[F_EDONE]  = erase_fault;
   assign flag_hw_clr[F_EFAIL]  = 1'b0;
   assign flag_hw_clr[F_OPDONE] = 1'b0;

   genvar gi;
   generate
      for (gi = 0; gi < FLAG_COUNT; gi++) begin : g_flag
         assign flags[gi].set    = flag_set[gi];
         assign flags[gi].sw_clr = flag_sw_clr[gi];
         assign flags[gi].hw_clr = flag_hw_clr[gi];
         assign flag_value[gi]   = flags[gi].value;
         event_flag u_flag (
            .mclk  (mclk),
            .rst_n (rst_n),
            .f     (flags[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // Sector write enables
   // ----------------------------------------
   generate
      for (gi = 0; gi < SECTOR_COUNT; gi++) begin : g_sector
         sector_lock u_lock (
            .mclk   (mclk),
            .rst_n  (rst_n),
            .wr     (wr_sector),
            .wbit   (bus_wdata[gi]),
            .enable (sector_write_enable[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // Control register writes
   // ----------------------------------------
   // Enables and options; bits 7,6 of control are not stored
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         write_done_irq_enable       <= 1'b0;
         write_fail_irq_enable       <= 1'b0;
         erase_done_irq_enable       <= 1'b0;
         erase_fail_irq_enable       <= 1'b0;
         operation_irq_enable        <= 1'b0;
         global_program_erase_enable <= 1'b0;
         sector_swap_enable          <= 1'b0;
         control_reserved            <= 1'b0;
         sector_reserved             <= '0;
      end else begin
         if (wr_events) begin
            write_done_irq_enable <= bus_wdata[WDONE_EN_BIT];
            write_fail_irq_enable <= bus_wdata[WFAIL_EN_BIT];
            erase_done_irq_enable <= bus_wdata[EDONE_EN_BIT];
            erase_fail_irq_enable <= bus_wdata[EFAIL_EN_BIT];
         end
         if (wr_control) begin
            operation_irq_enable        <= bus_wdata[OP_EN_BIT];
            global_program_erase_enable <= bus_wdata[GLOBAL_EN_BIT];
            sector_swap_enable          <= bus_wdata[SWAP_BIT];
            control_reserved            <= bus_wdata[RSVD_BIT];
         end
         if (wr_sector) begin
            sector_reserved <= bus_wdata[SECTOR_RSVD_LSB +: SECTOR_RSVD_W];
         end
      end
   end

   // ----------------------------------------
   // Address mapping
   // ----------------------------------------
   // Swap trades the lower second sector and the vector area
   function automatic sector_t map_of(input logic [15:0] a, input logic swap);
      sector_t s;
      s = SEC_NONE;
      if (a >= LOW_FIRST_BASE && a < LOW_SECOND_BASE) begin
         s = SEC_LOW_FIRST;
      end else if (a >= LOW_SECOND_BASE && a <= LOW_SECOND_LAST) begin
         s = swap ? SEC_UPPER : SEC_LOW_SECOND;
      end else if (a >= VECTOR_BASE) begin
         s = swap ? SEC_LOW_SECOND : SEC_UPPER;
      end else if (a >= UPPER_BASE) begin
         s = SEC_UPPER;
      end
      return s;
   endfunction : map_of

   wire sector_t cmd_sector = map_of(cmd_addr, sector_swap_enable);
   wire sector_t req_sector = map_of(map_addr, sector_swap_enable);

   // Sector enable of the command target
   wire target_enabled = (cmd_sector == SEC_LOW_FIRST)  ? sector_write_enable[0] :
                         (cmd_sector == SEC_LOW_SECOND) ? sector_write_enable[1] :
                         (cmd_sector == SEC_UPPER)      ? sector_write_enable[2] : 1'b0;

   // ----------------------------------------
   // Command acceptance
   // ----------------------------------------
   // Stale write or erase flags hold off a repeat of that kind; a stale operation done flag holds off both kinds
   wire op_stale     = op_seen & ~flag_value[F_OPDONE];
   wire write_block  = (write_seen & (~flag_value[F_WDONE] | flag_value[F_WFAIL])) | op_stale;
   wire erase_block  = (erase_seen & (~flag_value[F_EDONE] | flag_value[F_EFAIL])) | op_stale;
   // Strobes need the global enable above the sector enable
   wire may_modify   = global_program_erase_enable & target_enabled;
   wire idle_now     = (state == ST_IDLE);
   wire accept_write = cmd_write & idle_now & may_modify & ~write_block;
   wire accept_erase = cmd_erase & ~cmd_write & idle_now & may_modify & ~erase_block;
   wire accept_any   = accept_write | accept_erase;

   // ----------------------------------------
   // Operation sequencer
   // ----------------------------------------
   // Idle drops a fixed delay after issue, rises on the algorithm end
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (accept_any) begin
               next_state = ST_ARMING;
            end
         end
         ST_ARMING: begin
            if (alg_end) begin
               next_state = ST_IDLE;
            end else if (arm_cnt == CNT_LAST) begin
               next_state = ST_RUNNING;
            end
         end
         ST_RUNNING: begin
            if (alg_end) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // State and arming counter
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state   <= ST_IDLE;
         arm_cnt <= '0;
      end else begin
         state   <= next_state;
         arm_cnt <= accept_any ? CNT_ONE : (state == ST_ARMING) ? arm_cnt + CNT_ONE : '0;
      end
   end

   // Idle status shown to software
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         idle_status <= 1'b1;
      end else if (state == ST_ARMING && next_state == ST_RUNNING) begin
         idle_status <= 1'b0;
      end else if (alg_end) begin
         idle_status <= 1'b1;
      end
   end

   // Remembers which kinds have completed once
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         write_seen <= 1'b0;
         erase_seen <= 1'b0;
         op_seen    <= 1'b0;
      end else begin
         if (alg_write_done || alg_write_fail) begin
            write_seen <= 1'b1;
         end
         if (alg_erase_done || alg_erase_fail) begin
            erase_seen <= 1'b1;
         end
         if (alg_end) begin
            op_seen <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Strobes toward the array
   // ----------------------------------------
   // Read/reset passes even while busy
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         flash_write_go      <= 1'b0;
         flash_erase_go      <= 1'b0;
         flash_read_reset_go <= 1'b0;
         map_sector          <= SEC_NONE;
         swap_active         <= 1'b0;
      end else begin
         flash_write_go      <= accept_write;
         flash_erase_go      <= accept_erase;
         flash_read_reset_go <= cmd_read_reset;
         map_sector          <= req_sector;
         swap_active         <= sector_swap_enable;
      end
   end

   // ----------------------------------------
   // Interrupt request
   // ----------------------------------------
   wire irq_write_done = flag_value[F_WDONE]  & write_done_irq_enable;
   wire irq_write_fail = flag_value[F_WFAIL]  & write_fail_irq_enable;
   wire irq_erase_done = flag_value[F_EDONE]  & erase_done_irq_enable;
   wire irq_erase_fail = flag_value[F_EFAIL]  & erase_fail_irq_enable;
   wire irq_op_done    = flag_value[F_OPDONE] & operation_irq_enable;
   wire next_irq       = irq_write_done | irq_write_fail | irq_erase_done |
                         irq_erase_fail | irq_op_done;

   // Level request held while any enabled flag stands
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   // Flags read as one under a read-modify-write
   wire rmw_read = bus_rd & bus_rmw;
   wire [7:0] events_view = {write_done_irq_enable, flag_value[F_WDONE] | rmw_read,
                             write_fail_irq_enable, flag_value[F_WFAIL] | rmw_read,
                             erase_done_irq_enable, flag_value[F_EDONE] | rmw_read,
                             erase_fail_irq_enable, flag_value[F_EFAIL] | rmw_read};
   wire [7:0] control_view = {2'b00, flag_value[F_OPDONE] | rmw_read, idle_status,
                              control_reserved, operation_irq_enable,
                              global_program_erase_enable, sector_swap_enable};
   wire [7:0] sector_view = {sector_reserved, sector_write_enable};
   wire [7:0] progress_view = {4'h0, erase_suspended, erase_in_progress,
                               write_in_progress, command_fault};
   wire [7:0] next_rdata = ~bus_rd      ? REG_RESET     :
                           sel_events   ? events_view   :
                           sel_control  ? control_view  :
                           sel_sector   ? sector_view   :
                           sel_progress ? progress_view : REG_RESET;

   // Data stand only in the cycle after the read strobe
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bus_rdata <= REG_RESET;
      end else begin
         bus_rdata <= next_rdata;
      end
   end

endmodule : flash_operation_control
`default_nettype wire

// file: verification/flash_ctl_sva.sv
`default_nettype none
// ------
// Port checks
// ------
module flash_ctl_sva
   import flash_ctl_pkg::*;
(
   input wire logic                   mclk, rst_n, bus_rd, bus_rmw, cmd_write, cmd_erase, irq,
   input wire logic                   alg_write_done, alg_write_fail, alg_erase_done, alg_erase_fail,
   input wire logic                   flash_write_go, flash_erase_go, swap_active, idle_status,
   input wire logic [7:0]             bus_addr, bus_rdata,
   input wire logic [15:0]            map_addr,
   input wire flash_ctl_pkg::sector_t map_sector
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Any algorithm end
   wire ends_any = alg_write_done | alg_write_fail | alg_erase_done | alg_erase_fail;
   wire go_any   = flash_write_go | flash_erase_go;

   property p_ctl_top; bus_rd && bus_addr == CONTROL_ADDR |=> bus_rdata[7:6] == 2'b00; endproperty
   a_ctl_top: assert property (p_ctl_top) else $error("control top bits set");
   property p_prog_top; bus_rd && bus_addr == PROGRESS_ADDR |=> bus_rdata[7:4] == 4'h0; endproperty
   a_prog_top: assert property (p_prog_top) else $error("progress top bits set");
   property p_rmw; bus_rd && bus_rmw && bus_addr == EVENT_FLAGS_ADDR |=> (bus_rdata & 8'h55) == 8'h55; endproperty
   a_rmw: assert property (p_rmw) else $error("rmw flag read not one");
   property p_busy; (cmd_write || cmd_erase) && !idle_status |=> !go_any; endproperty
   a_busy: assert property (p_busy) else $error("start while busy");
   // Idle holds two edges after a start
   property p_idle_fall; go_any |-> idle_status [*2] ##1 !idle_status; endproperty
   a_idle_fall: assert property (p_idle_fall) else $error("idle fall timing");
   property p_end_idle; ends_any && !idle_status |=> idle_status; endproperty
   a_end_idle: assert property (p_end_idle) else $error("idle not back after end");
   property p_rst; $rose(rst_n) |-> !irq && idle_status; endproperty
   a_rst: assert property (p_rst) else $error("request pending after reset");
   // Swap flag may lag a cycle
   property p_swap; swap_active && map_addr[15:11] == 5'h17 |=> !swap_active || map_sector == SEC_UPPER; endproperty
   a_swap: assert property (p_swap) else $error("swapped map wrong");

   c_write: cover property (flash_write_go);
   c_erase: cover property (flash_erase_go);
   c_irq: cover property (ends_any ##2 irq);
endmodule : flash_ctl_sva

bind flash_operation_control flash_ctl_sva i_sva (.*);
`default_nettype wire

// file: verification/flash_alg_model.sv
`default_nettype none
// ------
// Automatic algorithm stand-in
// ------
module flash_alg_model #(
   parameter int LAT = 8
) (
   input wire logic mclk, rst_n, write_go, erase_go, fail,
   output logic     write_done, write_fail, erase_done, erase_fail, fault, writing, erasing
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   // Fixed run time, one end pulse; fault rises on failure
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 0;
         {write_done, write_fail, erase_done, erase_fail, fault, writing, erasing} <= '0;
      end else begin
         {write_done, write_fail, erase_done, erase_fail} <= '0;
         if (write_go || erase_go) begin
            cnt <= LAT;
            writing <= write_go;
            erasing <= erase_go;
            fault <= 1'b0;
         end else if (cnt == 1) begin
            cnt <= 0;
            {write_done, write_fail} <= {writing & ~fail, writing & fail};
            {erase_done, erase_fail} <= {erasing & ~fail, erasing & fail};
            {fault, writing, erasing} <= {fail, 2'b00};
         end else if (cnt != 0) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule : flash_alg_model
`default_nettype wire

// file: verification/flash_operation_control_tb.sv
`default_nettype none
module flash_operation_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import flash_ctl_pkg::*;
   typedef struct {logic w; logic [15:0] a; logic f; logic [7:0] dg; logic [7:0] fl;} row_t;
   logic        mclk, rst_n, bus_wr, bus_rd, bus_rmw, cmd_write, cmd_erase, cmd_read_reset, fail;
   logic [7:0]  bus_addr, bus_wdata, bus_rdata;
   logic [15:0] cmd_addr, map_addr;
   logic        alg_write_done, alg_write_fail, alg_erase_done, alg_erase_fail, command_fault, erase_suspended;
   logic        write_in_progress, erase_in_progress, swap_active, idle_status, irq;
   logic        flash_write_go, flash_erase_go, flash_read_reset_go;
   sector_t     map_sector;
   int          mismatches, compares, gos;
   row_t        rows [6];

   flash_operation_control i_dut (.*);
   flash_alg_model i_alg (.mclk, .rst_n, .write_go(flash_write_go), .erase_go(flash_erase_go), .fail,
      .write_done(alg_write_done), .write_fail(alg_write_fail), .erase_done(alg_erase_done),
      .erase_fail(alg_erase_fail), .fault(command_fault), .writing(write_in_progress),
      .erasing(erase_in_progress));

   // ------
   // Clock and tasks
   // ------
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   always @(posedge mclk) if (flash_write_go === 1'b1 || flash_erase_go === 1'b1) gos++;

   task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      {bus_addr, bus_wdata, bus_wr} <= {a, d, 1'b1};
      @(posedge mclk);
      bus_wr <= 1'b0;
   endtask : wr
   // Data stand in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] exp);
      @(posedge mclk);
      {bus_addr, bus_rmw, bus_rd} <= {a, m, 1'b1};
      @(posedge mclk);
      {bus_rmw, bus_rd} <= 2'b00;
      #1 chk("rdata", bus_rdata, exp);
   endtask : rd
   // Start pulse, then wait n edges
   task automatic op(input logic w, input logic [15:0] a, input logic f, input int n);
      @(posedge mclk);
      {fail, cmd_addr, cmd_write, cmd_erase} <= {f, a, w, !w};
      @(posedge mclk);
      {cmd_write, cmd_erase} <= 2'b00;
      repeat (n) @(posedge mclk);
   endtask : op
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
   endtask : do_reset
   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : summarize

   initial begin
      repeat (3000) @(posedge mclk);
      mismatches++;
      summarize();
   end

   // ------
   // Table, then awkward cases
   // ------
   initial begin
      {rst_n, bus_wr, bus_rd, bus_rmw, cmd_write, cmd_erase, cmd_read_reset, fail, erase_suspended} = '0;
      {bus_addr, bus_wdata, cmd_addr, map_addr} = '0;
      rows = '{'{1, 16'hb000, 0, 1, 8'hea}, '{0, 16'hb800, 0, 2, 8'hee}, '{1, 16'hf800, 1, 3, 8'hbe},
               '{1, 16'hb000, 0, 3, 8'hbe}, '{0, 16'hb000, 1, 4, 8'hbb}, '{0, 16'hb800, 0, 4, 8'hbb}};
      do_reset();
      rd(EVENT_FLAGS_ADDR, 0, 8'h00);
      rd(CONTROL_ADDR, 0, 8'h10);
      rd(8'h70, 0, 8'h00);
      wr(SECTOR_WE_ADDR, 8'h07);
      wr(CONTROL_ADDR, 8'h02);
      wr(EVENT_FLAGS_ADDR, 8'haa);
      foreach (rows[i]) begin
         op(rows[i].w, rows[i].a, rows[i].f, 14);
         chk("starts", gos[7:0], rows[i].dg);
         rd(EVENT_FLAGS_ADDR, 0, rows[i].fl);
         chk("irq", {7'h0, irq}, 8'h01);
      end
      $display("table done");
      rd(EVENT_FLAGS_ADDR, 1, 8'hff);
      wr(EVENT_FLAGS_ADDR, 8'hff);
      rd(EVENT_FLAGS_ADDR, 0, 8'hbb);
      wr(EVENT_FLAGS_ADDR, 8'haa);
      repeat (2) @(posedge mclk);
      #1 chk("irq", {7'h0, irq}, 8'h00);
      op(1, 16'hb000, 0, 14);
      chk("starts", gos[7:0], 8'h04);
      $display("flag test done");
      do_reset();
      wr(SECTOR_WE_ADDR, 8'h07);
      op(1, 16'hb000, 0, 14);
      chk("starts", gos[7:0], 8'h04);
      wr(CONTROL_ADDR, 8'h06);
      op(1, 16'hb000, 0, 2);
      #1 chk("idle", {7'h0, idle_status}, 8'h00);
      erase_suspended <= 1'b1;
      rd(PROGRESS_ADDR, 0, 8'h0a);
      @(posedge mclk);
      {cmd_write, cmd_read_reset} <= 2'b11;
      @(posedge mclk);
      {cmd_write, cmd_read_reset} <= 2'b00;
      #1 chk("read reset", {7'h0, flash_read_reset_go}, 8'h01);
      repeat (14) @(posedge mclk);
      chk("starts", gos[7:0], 8'h05);
      rd(CONTROL_ADDR, 0, 8'h36);
      chk("irq", {7'h0, irq}, 8'h01);
      $display("command test done");
      wr(SECTOR_WE_ADDR, 8'h06);
      wr(SECTOR_WE_ADDR, 8'h07);
      rd(SECTOR_WE_ADDR, 0, 8'h06);
      op(1, 16'hb000, 0, 14);
      chk("starts", gos[7:0], 8'h05);
      wr(CONTROL_ADDR, 8'hc7);
      rd(CONTROL_ADDR, 0, 8'h17);
      map_addr <= 16'hf800;
      repeat (2) @(posedge mclk);
      #1 chk("sector", {6'h0, map_sector}, {6'h0, SEC_LOW_SECOND});
      map_addr <= 16'hb800;
      repeat (2) @(posedge mclk);
      #1 chk("sector", {6'h0, map_sector}, {6'h0, SEC_UPPER});
      chk("swap", {7'h0, swap_active}, 8'h01);
      $display("lock and map test done");
      summarize();
   end
endmodule : flash_operation_control_tb
`default_nettype wire
